// *** src/pctag_pkg.sv ***
// Constants, field layouts and operation codes of the primary cache tag block.
// Assumes a single 20 MHz core clock; all users name items as pctag_pkg::name.
// Notes on behaviour
// - Two separate 16KByte primary caches, one for instructions, one for data.
// - Each cache has two ways; a line holds eight 32-bit words, 32 bytes.
// - Virtual address bits index the array; stored physical tag decides hit.
// - Instruction tag is 28 bits: frame tag, valid, reserved, parity, replacement bit.
// - The frame tag holds physical address bits 35 down to 12.
// - Every data line refill inverts the replacement bit, giving FIFO way choice; instruction fills leave the tag alone.
// - Instruction tag parity is even over frame tag and valid bit.
// - Instruction data carries one even parity bit per 32-bit word.
// - Data tag is 30 bits: frame tag, state, write-back, two parities, replacement.
// - Line state codes: 0 invalid, 1 shared, 2 clean exclusive, 3 dirty exclusive.
// - Write-back bit sets when the line is written; its own bit holds even parity.
// - Data tag parity is even over frame tag and line state.
// - Data contents carry one even parity bit per byte.
// - After reset tags, parity and data are undefined; nothing clears them.
// - Indexed operations pick line from VA bits 12..5 and way from VA bit 13.
// - Hit operations act only on a valid matching way; a miss does nothing.
// - Indexed tag store copies staging into the line; 0x9 data, 0x8 instruction.
// - Operation 0x14 fills an instruction line from memory.
// - Any load miss block-reads and refills the whole line, into an invalid way or else the FIFO way.
// - Reserved staging fields read zero; software writes zero there.
package pctag_pkg;
   // ****************************************
   // Geometry
   // ****************************************
   localparam int CACHE_BYTES = 16384;
   localparam int WAYS = 2;
   localparam int WORDS = 8;
   localparam int LINES = CACHE_BYTES / (WAYS * WORDS * 4);
   localparam int LINE_W = 8;
   localparam int WORD_W = 3;
   localparam int VA_W = 14;
   localparam int PA_W = 36;
   localparam int LINE_LSB = 5;
   localparam int WORD_LSB = 2;
   localparam int WAY_BIT = 13;
   localparam int PHYS_FRAME_TAG_LSB = 12;
   localparam int PHYS_FRAME_TAG_W = 24;
   localparam int ITAG_W = 28;
   localparam int DTAG_W = 30;
   // ****************************************
   // Tag array layouts
   // ****************************************
   localparam int IT_PHYS_FRAME_TAG = 4;
   localparam int IT_V = 3;
   localparam int IT_P = 1;
   localparam int IT_F = 0;
   localparam int DT_PHYS_FRAME_TAG = 6;
   localparam int DT_CS = 4;
   localparam int DT_W = 3;
   localparam int DT_WP = 2;
   localparam int DT_P = 1;
   localparam int DT_F = 0;
   // ****************************************
   // Staging register layouts
   // ****************************************
   localparam int LO_PHYS_FRAME_TAG = 8;
   localparam int LO_CS = 6;
   localparam int LO_F = 1;
   localparam int LO_P = 0;
   localparam logic [31:0] LO_MASK = 32'hFFFFFFC3;
   localparam logic [31:0] HI_MASK = 32'h00000003;
   localparam logic [31:0] STAGE_RST = 32'h00000000;
   // ****************************************
   // Line states and requests
   // ****************************************
   localparam logic [1:0] CS_INVALID = 2'h0;
   localparam logic [1:0] CS_SHARED = 2'h1;
   localparam logic [1:0] CS_CLEAN = 2'h2;
   localparam logic [1:0] CS_DIRTY = 2'h3;
   localparam logic [1:0] KIND_CACHE = 2'h0;
   localparam logic [1:0] KIND_LOAD = 2'h1;
   localparam logic [1:0] KIND_STORE = 2'h2;
   localparam logic [4:0] OP_ILT_I = 5'h04;
   localparam logic [4:0] OP_ILT_D = 5'h05;
   localparam logic [4:0] OP_IST_I = 5'h08;
   localparam logic [4:0] OP_IST_D = 5'h09;
   localparam logic [4:0] OP_HINV_I = 5'h10;
   localparam logic [4:0] OP_HINV_D = 5'h11;
   localparam logic [4:0] OP_FILL_I = 5'h14;
   typedef enum logic [2:0] {PCT_IDLE = 3'b001, PCT_REQ = 3'b010, PCT_FILL = 3'b100} pctag_state_t;
endpackage

// *** src/pctag_top.sv ***
// Primary instruction and data caches with tag staging and maintenance operations.
// Assumes requests and memory beats come from logic on mclk_in; one request at a time.
`timescale 1ns/1ps
module pctag_top
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic stage_wr_in,
   input wire logic stage_sel_in,
   input wire logic [31:0] stage_wdata_in,
   output logic [31:0] stage_rdata_out,
   input wire logic req_valid_in,
   input wire logic [1:0] req_kind_in,
   input wire logic [4:0] req_op_in,
   input wire logic [13:0] req_vaddr_in,
   input wire logic [35:0] req_paddr_in,
   input wire logic [31:0] req_wdata_in,
   input wire logic [3:0] req_be_in,
   output logic busy_out,
   output logic done_out,
   output logic hit_out,
   output logic [31:0] ld_data_out,
   output logic mem_req_out,
   output logic [35:0] mem_addr_out,
   input wire logic mem_valid_in,
   input wire logic [31:0] mem_word_in
);
   // ****************************************
   // Storage: cache arrays are flops with no reset, contents undefined until software initialises; staging and control registers reset
   // ****************************************
   logic [pctag_pkg::ITAG_W-1:0] itag [0:2*pctag_pkg::LINES-1];
   logic [pctag_pkg::DTAG_W-1:0] dtag [0:2*pctag_pkg::LINES-1];
   logic [32:0] idata [0:2*pctag_pkg::LINES*pctag_pkg::WORDS-1];
   logic [35:0] ddata [0:2*pctag_pkg::LINES*pctag_pkg::WORDS-1];
   logic [31:0] tag_low_staging;
   logic [31:0] tag_high_staging;
   pctag_pkg::pctag_state_t state;
   pctag_pkg::pctag_state_t next_state;
   logic fill_icache;
   logic fill_load;
   logic fill_way;
   logic [7:0] fill_line;
   logic [23:0] fill_phys_frame_tag;
   logic [2:0] fill_word;
   logic [2:0] beat;
   logic [31:0] fill_pick;

   function automatic logic [27:0] mk_itag(input logic [23:0] pt, input logic v, input logic f);
      mk_itag = {pt, v, 1'b0, ^{pt, v}, f};
   endfunction

   function automatic logic [29:0] mk_dtag(input logic [23:0] pt, input logic [1:0] cs,
                                           input logic w, input logic f);
      mk_dtag = {pt, cs, w, w, ^{pt, cs}, f};
   endfunction

   function automatic logic [3:0] byte_par(input logic [31:0] w);
      byte_par = {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
   endfunction

   // ****************************************
   // Request decode
   // ****************************************
   logic [7:0] line;
   logic [2:0] word;
   logic [23:0] phys_frame_tag;
   logic [8:0] idx;
   logic [8:0] idx0;
   logic [8:0] idx1;
   logic acc;
   logic [27:0] it0;
   logic [27:0] it1;
   logic [29:0] dt0;
   logic [29:0] dt1;
   logic ih0;
   logic ih1;
   logic dh0;
   logic dh1;
   logic dv0;
   logic dv1;
   logic dhw;
   logic ihw;
   logic vway;
   logic is_load;
   logic is_store;
   logic is_op;
   logic [31:0] lo_wr;
   logic [29:0] dhit_tag;
   logic [11:0] dw_idx;
   logic last_beat;
   logic [8:0] fidx;
   logic [11:0] fw_idx;
   logic [27:0] it_sel;
   logic [31:0] merged;

   assign line = req_vaddr_in[pctag_pkg::LINE_LSB +: pctag_pkg::LINE_W];
   assign word = req_vaddr_in[pctag_pkg::WORD_LSB +: pctag_pkg::WORD_W];
   assign phys_frame_tag = req_paddr_in[pctag_pkg::PHYS_FRAME_TAG_LSB +: pctag_pkg::PHYS_FRAME_TAG_W];
   assign idx = {req_vaddr_in[pctag_pkg::WAY_BIT], line};
   assign idx0 = {1'b0, line};
   assign idx1 = {1'b1, line};
   assign acc = req_valid_in && state == pctag_pkg::PCT_IDLE && clk_en_in;
   assign is_load = acc && req_kind_in == pctag_pkg::KIND_LOAD;
   assign is_store = acc && req_kind_in == pctag_pkg::KIND_STORE;
   assign is_op = acc && req_kind_in == pctag_pkg::KIND_CACHE;
   assign it0 = itag[idx0];
   assign it1 = itag[idx1];
   assign dt0 = dtag[idx0];
   assign dt1 = dtag[idx1];
   assign dv0 = dt0[pctag_pkg::DT_CS +: 2] != pctag_pkg::CS_INVALID;
   assign dv1 = dt1[pctag_pkg::DT_CS +: 2] != pctag_pkg::CS_INVALID;
   assign ih0 = it0[pctag_pkg::IT_V] && it0[pctag_pkg::IT_PHYS_FRAME_TAG +: pctag_pkg::PHYS_FRAME_TAG_W] == phys_frame_tag;
   assign ih1 = it1[pctag_pkg::IT_V] && it1[pctag_pkg::IT_PHYS_FRAME_TAG +: pctag_pkg::PHYS_FRAME_TAG_W] == phys_frame_tag;
   assign dh0 = dv0 && dt0[pctag_pkg::DT_PHYS_FRAME_TAG +: pctag_pkg::PHYS_FRAME_TAG_W] == phys_frame_tag;
   assign dh1 = dv1 && dt1[pctag_pkg::DT_PHYS_FRAME_TAG +: pctag_pkg::PHYS_FRAME_TAG_W] == phys_frame_tag;
   assign dhw = dh1;
   assign ihw = ih1;
   assign dhit_tag = dhw ? dt1 : dt0;
   assign dw_idx = {dhw, line, word};
   // FIFO choice: an invalid way first, otherwise the way whose flip is due
   assign vway = !dv0 ? 1'b0 : (!dv1 ? 1'b1 : dt0[pctag_pkg::DT_F] ^ dt1[pctag_pkg::DT_F]);
   assign lo_wr = stage_wdata_in & pctag_pkg::LO_MASK;
   assign last_beat = state == pctag_pkg::PCT_FILL && mem_valid_in && beat == 3'h7;
   assign fidx = {fill_way, fill_line};
   assign fw_idx = {fill_way, fill_line, beat};
   assign it_sel = req_vaddr_in[pctag_pkg::WAY_BIT] ? it1 : it0;

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb
   begin
      next_state = state;
      case (state)
         pctag_pkg::PCT_IDLE:
         begin
            if (is_op && req_op_in == pctag_pkg::OP_FILL_I)
               next_state = pctag_pkg::PCT_REQ;
            else if (is_load && !(dh0 || dh1))
               next_state = pctag_pkg::PCT_REQ;
         end
         pctag_pkg::PCT_REQ:
            next_state = pctag_pkg::PCT_FILL;
         pctag_pkg::PCT_FILL:
         begin
            if (last_beat)
               next_state = pctag_pkg::PCT_IDLE;
         end
         default:
            next_state = pctag_pkg::PCT_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
      begin
         state <= pctag_pkg::PCT_IDLE;
         busy_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         state <= next_state;
         busy_out <= next_state != pctag_pkg::PCT_IDLE;
      end
   end

   // Fill context is captured as the miss or fill is taken
   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
      begin
         fill_icache <= 1'b0;
         fill_load <= 1'b0;
         fill_way <= 1'b0;
         fill_line <= 8'h00;
         fill_phys_frame_tag <= 24'h000000;
         fill_word <= 3'h0;
         beat <= 3'h0;
         mem_req_out <= 1'b0;
         mem_addr_out <= 36'h000000000;
      end
      else if (clk_en_in)
      begin
         mem_req_out <= state == pctag_pkg::PCT_IDLE && next_state == pctag_pkg::PCT_REQ;
         if (state == pctag_pkg::PCT_IDLE && next_state == pctag_pkg::PCT_REQ)
         begin
            fill_icache <= is_op;
            fill_load <= is_load;
            fill_way <= is_op ? req_vaddr_in[pctag_pkg::WAY_BIT] : vway;
            fill_line <= line;
            fill_phys_frame_tag <= phys_frame_tag;
            fill_word <= word;
            beat <= 3'h0;
            mem_addr_out <= {req_paddr_in[35:5], 5'h00};
         end
         else if (state == pctag_pkg::PCT_FILL && mem_valid_in)
            beat <= beat + 3'h1;
      end
   end

   // ****************************************
   // Tag staging registers
   // ****************************************
   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
      begin
         tag_low_staging <= pctag_pkg::STAGE_RST;
         tag_high_staging <= pctag_pkg::STAGE_RST;
         stage_rdata_out <= pctag_pkg::STAGE_RST;
      end
      else if (clk_en_in)
      begin
         if (is_op && req_op_in == pctag_pkg::OP_ILT_I)
            tag_low_staging <= {it_sel[27:4], it_sel[pctag_pkg::IT_V], 5'h00, it_sel[pctag_pkg::IT_F],
                                it_sel[pctag_pkg::IT_P]};
         else if (is_op && req_op_in == pctag_pkg::OP_ILT_D)
            tag_low_staging <= {dtag[idx][29:4], 4'h0, dtag[idx][0], dtag[idx][1]};
         else if (stage_wr_in && !stage_sel_in)
            tag_low_staging <= lo_wr;
         if (stage_wr_in && stage_sel_in)
            tag_high_staging <= stage_wdata_in & pctag_pkg::HI_MASK;
         stage_rdata_out <= stage_sel_in ? tag_high_staging : tag_low_staging;
      end
   end

   // ****************************************
   // Tag arrays
   // ****************************************
   always_ff @(posedge mclk_in)
   begin
      if (clk_en_in && !reset_in)
      begin
         if (is_op && req_op_in == pctag_pkg::OP_IST_I)
            itag[idx] <= {tag_low_staging[31:8], tag_low_staging[7], 1'b0,
                          tag_low_staging[pctag_pkg::LO_P], tag_low_staging[pctag_pkg::LO_F]};
         else if (is_op && req_op_in == pctag_pkg::OP_HINV_I && (ih0 || ih1))
            itag[{ihw, line}] <= mk_itag(phys_frame_tag, 1'b0, ihw ? it1[pctag_pkg::IT_F] : it0[pctag_pkg::IT_F]);
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (clk_en_in && !reset_in)
      begin
         if (is_op && req_op_in == pctag_pkg::OP_IST_D)
            dtag[idx] <= {tag_low_staging[31:6], 2'b00,
                          tag_low_staging[pctag_pkg::LO_P], tag_low_staging[pctag_pkg::LO_F]};
         else if (is_op && req_op_in == pctag_pkg::OP_HINV_D && (dh0 || dh1))
            dtag[{dhw, line}] <= mk_dtag(phys_frame_tag, pctag_pkg::CS_INVALID, 1'b0, dhit_tag[pctag_pkg::DT_F]);
         else if (is_store && (dh0 || dh1))
            dtag[{dhw, line}] <= mk_dtag(phys_frame_tag, pctag_pkg::CS_DIRTY, 1'b1, dhit_tag[pctag_pkg::DT_F]);
         else if (last_beat && fill_load)
            dtag[fidx] <= mk_dtag(fill_phys_frame_tag, pctag_pkg::CS_CLEAN, 1'b0, !dtag[fidx][pctag_pkg::DT_F]);
      end
   end

   // ****************************************
   // Data arrays, parity generated on every write
   // ****************************************
   always_ff @(posedge mclk_in)
   begin
      if (clk_en_in && !reset_in && state == pctag_pkg::PCT_FILL && mem_valid_in && fill_icache)
         idata[fw_idx] <= {^mem_word_in, mem_word_in};
   end

   // Byte merge for store hits; bytes without enable keep their stored value
   always_comb
   begin
      merged = ddata[dw_idx][31:0];
      for (int b = 0; b < 4; b++)
      begin
         if (req_be_in[b])
            merged[8*b +: 8] = req_wdata_in[8*b +: 8];
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (clk_en_in && !reset_in)
      begin
         if (state == pctag_pkg::PCT_FILL && mem_valid_in && fill_load)
            ddata[fw_idx] <= {byte_par(mem_word_in), mem_word_in};
         else if (is_store && (dh0 || dh1))
            ddata[dw_idx] <= {byte_par(merged), merged};
      end
   end

   // ****************************************
   // Completion
   // ****************************************
   assign fill_pick = mem_word_in;
   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
      begin
         done_out <= 1'b0;
         hit_out <= 1'b0;
         ld_data_out <= 32'h00000000;
      end
      else if (clk_en_in)
      begin
         done_out <= last_beat || (acc && next_state == pctag_pkg::PCT_IDLE);
         if (acc)
            hit_out <= is_load || is_store ? (dh0 || dh1) :
                       (req_op_in == pctag_pkg::OP_HINV_I ? (ih0 || ih1) :
                       (req_op_in == pctag_pkg::OP_HINV_D ? (dh0 || dh1) : 1'b0));
         if (is_load && (dh0 || dh1))
            ld_data_out <= ddata[dw_idx][31:0];
         else if (state == pctag_pkg::PCT_FILL && mem_valid_in && fill_load && beat == fill_word)
            ld_data_out <= fill_pick;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [8:0] chk_idx;
   always_ff @(posedge mclk_in)
      chk_idx <= reset_in ? 9'h000 : (acc ? (is_store ? {dhw, line} : idx) : chk_idx);

   sequence s_miss;
      is_load && !(dh0 || dh1);
   endsequence
   sequence s_block_read;
      ##1 (busy_out && mem_req_out) ##1 busy_out;
   endsequence

   miss_reads_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      s_miss |-> s_block_read) else $error("load miss did not start block read");
   req_pulse_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      mem_req_out && clk_en_in |=> !mem_req_out) else $error("memory request longer than a cycle");
   stage_zero_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (tag_low_staging & ~pctag_pkg::LO_MASK) == 32'h0 && (tag_high_staging & ~pctag_pkg::HI_MASK) == 32'h0)
      else $error("reserved staging bits not zero");
   zero_inval_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      is_op && req_op_in == pctag_pkg::OP_IST_D && tag_low_staging == 32'h0 |=> dtag[chk_idx] == 30'h0)
      else $error("zero tag store did not invalidate");
   fifo_flip_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      last_beat && fill_load |=> dtag[fidx][pctag_pkg::DT_F] != $past(dtag[fidx][pctag_pkg::DT_F]))
      else $error("replacement bit not inverted on refill");
   dpar_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      last_beat && fill_load |=> ^dtag[fidx][29:4] == dtag[fidx][pctag_pkg::DT_P])
      else $error("data tag parity wrong after refill");
   wb_dirty_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      is_store && (dh0 || dh1) |=> hit_out && done_out && dtag[chk_idx][pctag_pkg::DT_W] &&
      dtag[chk_idx][pctag_pkg::DT_WP] && dtag[chk_idx][pctag_pkg::DT_CS +: 2] == pctag_pkg::CS_DIRTY)
      else $error("write-back parity broken");
   miss_noop_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      is_op && req_op_in == pctag_pkg::OP_HINV_D && !(dh0 || dh1) |=> done_out && !hit_out)
      else $error("hit operation acted on a miss");
   fill_len_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      last_beat && clk_en_in |=> done_out && !busy_out) else $error("refill not eight words");
endmodule

// *** tb/pctag_mem_model.sv ***
// Memory partner of the primary cache block: answers each block read with eight words.
// Assumes mem_req_in is a one-cycle pulse on mclk_in; slow_in spaces the beats out.
`timescale 1ns/1ps
module pctag_mem_model
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic mem_req_in,
   input wire logic [35:0] mem_addr_in,
   input wire logic slow_in,
   output logic mem_valid_out,
   output logic [31:0] mem_word_out,
   output logic [7:0] blocks_out
);
   logic active;
   logic [2:0] beat;
   logic [1:0] gap;
   logic [35:0] base;
   // ****************************************
   // Block read responder
   // ****************************************
   // Each word equals its own byte address, so the bench can predict it
   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
      begin
         active <= 1'b0;
         mem_valid_out <= 1'b0;
         mem_word_out <= 32'h00000000;
         blocks_out <= 8'h00;
      end
      else
      begin
         mem_valid_out <= 1'b0;
         // Idle bus never repeats the last word, so a late sample shows up
         mem_word_out <= ~mem_word_out;
         if (mem_req_in)
         begin
            active <= 1'b1;
            beat <= 3'h0;
            base <= mem_addr_in;
            gap <= slow_in ? 2'h3 : 2'h0;
            blocks_out <= blocks_out + 8'h01;
         end
         else if (active && gap != 2'h0)
            gap <= gap - 2'h1;
         else if (active)
         begin
            mem_valid_out <= 1'b1;
            mem_word_out <= base[31:0] + {27'h0, beat, 2'h0};
            beat <= beat + 3'h1;
            active <= (beat != 3'h7);
            gap <= slow_in ? 2'h1 : 2'h0;
         end
      end
   end
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the primary cache tag block: staging, tag ops, loads, stores, fills.
// Assumes pctag_pkg and pctag_top from src/ and the memory partner from tb/.
`timescale 1ns/1ps
module tb;
   logic mclk_in, reset_in, clk_en_in, stage_wr_in, stage_sel_in, req_valid_in, busy_out;
   logic done_out, hit_out, mem_req_out, mem_valid_in, slow, hit;
   logic [31:0] stage_wdata_in, stage_rdata_out, req_wdata_in, ld_data_out, mem_word_in, data, d;
   logic [1:0] req_kind_in;
   logic [4:0] req_op_in;
   logic [13:0] req_vaddr_in, va;
   logic [35:0] req_paddr_in, mem_addr_out, pa_a, pa_b, pa_c;
   logic [3:0] req_be_in;
   logic [7:0] blocks, nb, ln;
   int miscompares = 0;
   int n_tests = 0;
   pctag_top uut (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .stage_wr_in(stage_wr_in),
      .stage_sel_in(stage_sel_in), .stage_wdata_in(stage_wdata_in), .stage_rdata_out(stage_rdata_out),
      .req_valid_in(req_valid_in), .req_kind_in(req_kind_in), .req_op_in(req_op_in),
      .req_vaddr_in(req_vaddr_in), .req_paddr_in(req_paddr_in), .req_wdata_in(req_wdata_in),
      .req_be_in(req_be_in), .busy_out(busy_out), .done_out(done_out), .hit_out(hit_out),
      .ld_data_out(ld_data_out), .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
      .mem_valid_in(mem_valid_in), .mem_word_in(mem_word_in));
   pctag_mem_model mem (.mclk_in(mclk_in), .reset_in(reset_in), .mem_req_in(mem_req_out),
      .mem_addr_in(mem_addr_out), .slow_in(slow), .mem_valid_out(mem_valid_in), .mem_word_out(mem_word_in),
      .blocks_out(blocks));
   always #25 mclk_in = ~mclk_in;
   // ****************************************
   // Access tasks
   // ****************************************
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic st_wr(input logic sel, input logic [31:0] wd);
      @(negedge mclk_in);
      stage_wr_in = 1'b1;
      stage_sel_in = sel;
      stage_wdata_in = wd;
      @(negedge mclk_in);
      stage_wr_in = 1'b0;
   endtask
   task automatic st_rd(input logic sel);
      @(negedge mclk_in);
      stage_sel_in = sel;
      @(negedge mclk_in);
      d = stage_rdata_out;
   endtask
   // Waits a bounded time for completion; the request is offered for one edge only
   task automatic req(input logic [1:0] k, input logic [4:0] op, input logic [13:0] v, input logic [35:0] p,
      input logic [31:0] wd, input logic [3:0] be);
      int n;
      @(negedge mclk_in);
      req_valid_in = 1'b1;
      req_kind_in = k;
      req_op_in = op;
      req_vaddr_in = v;
      req_paddr_in = p;
      req_wdata_in = wd;
      req_be_in = be;
      @(negedge mclk_in);
      req_valid_in = 1'b0;
      n = 0;
      while (done_out !== 1'b1 && n < 60)
      begin
         @(negedge mclk_in);
         n++;
      end
      chk(n < 60, 1'b1, "completion");
      hit = hit_out;
      data = ld_data_out;
   endtask
   function automatic logic [31:0] lo_d(input logic [23:0] pt, input logic [1:0] st, input logic f);
      return {pt, st, 4'h0, f, ^{pt, st}};
   endfunction
   function automatic logic [31:0] wd_of(input logic [35:0] pa);
      return {pa[31:2], 2'h0};
   endfunction
   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      {mclk_in, clk_en_in, reset_in} = 3'h7;
      {stage_wr_in, stage_sel_in, req_valid_in, slow} = 4'h0;
      {stage_wdata_in, req_wdata_in, req_be_in, req_kind_in, req_op_in} = 0;
      {req_vaddr_in, req_paddr_in} = 0;
      repeat (5) @(negedge mclk_in);
      reset_in = 1'b0;
      st_wr(1'b0, 32'hFFFFFFFF);
      st_rd(1'b0);
      chk(d, 32'hFFFFFFC3, "low staging mask");
      st_wr(1'b1, 32'hFFFFFFFF);
      st_rd(1'b1);
      chk(d, 32'h00000003, "high staging mask");
      st_wr(1'b1, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         ln = i ? 8'hFF : 8'h00;
         slow = i[0];
         va = {1'b0, ln, 5'h14};
         pa_a = {24'h123456, va[11:0]};
         pa_b = {24'h654321, va[11:0]};
         pa_c = {24'h0F0F0F, va[11:0]};
         st_wr(1'b0, 32'h0);
         for (int w = 0; w < 2; w++)
            req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_IST_D, {w[0], ln, 5'h0}, 0, 0, 0);
         nb = blocks;
         req(pctag_pkg::KIND_LOAD, 5'h0, va, pa_a, 0, 0);
         chk({hit, data, blocks}, {1'b0, wd_of(pa_a), nb + 8'h01}, "load miss refill");
         chk(mem_addr_out, {pa_a[35:5], 5'h0}, "block address");
         req(pctag_pkg::KIND_LOAD, 5'h0, va ^ 14'h1C, pa_a ^ 36'h1C, 0, 0);
         chk({hit, data, blocks}, {1'b1, wd_of(pa_a ^ 36'h1C), nb + 8'h01}, "load hit");
         req(pctag_pkg::KIND_LOAD, 5'h0, va, pa_b, 0, 0);
         chk({hit, data}, {1'b0, wd_of(pa_b)}, "second way refill");
         req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_ILT_D, {1'b0, ln, 5'h0}, 0, 0, 0);
         st_rd(1'b0);
         chk(d, lo_d(24'h123456, pctag_pkg::CS_CLEAN, 1'b1), "way0 tag");
         req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_ILT_D, {1'b1, ln, 5'h0}, 0, 0, 0);
         st_rd(1'b0);
         chk(d, lo_d(24'h654321, pctag_pkg::CS_CLEAN, 1'b1), "way1 tag");
         req(pctag_pkg::KIND_STORE, 5'h0, va, pa_b, 32'hA5A5A5A5, 4'b0010);
         chk(hit, 1'b1, "store hit");
         req(pctag_pkg::KIND_LOAD, 5'h0, va, pa_b, 0, 0);
         chk({hit, data}, {1'b1, wd_of(pa_b) & 32'hFFFF00FF | 32'h0000A500}, "merged store");
         req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_ILT_D, {1'b1, ln, 5'h0}, 0, 0, 0);
         st_rd(1'b0);
         chk(d, lo_d(24'h654321, pctag_pkg::CS_DIRTY, 1'b1), "dirty tag");
         nb = blocks;
         req(pctag_pkg::KIND_STORE, 5'h0, va, pa_c, 32'h0, 4'hF);
         chk({hit, blocks}, {1'b0, nb}, "store miss");
         req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_HINV_D, va, pa_c, 0, 0);
         chk(hit, 1'b0, "invalidate miss");
         req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_HINV_D, va, pa_a, 0, 0);
         chk(hit, 1'b1, "invalidate hit");
         req(pctag_pkg::KIND_LOAD, 5'h0, va, pa_a, 0, 0);
         chk({hit, blocks}, {1'b0, nb + 8'h01}, "load after invalidate");
         req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_ILT_D, {1'b0, ln, 5'h0}, 0, 0, 0);
         st_rd(1'b0);
         chk(d, lo_d(24'h123456, pctag_pkg::CS_CLEAN, 1'b0), "second refill order bit");
         st_wr(1'b0, 32'h0);
         req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_IST_D, {1'b1, ln, 5'h0}, 0, 0, 0);
         req(pctag_pkg::KIND_LOAD, 5'h0, va, pa_b, 0, 0);
         chk(hit, 1'b0, "zero tag store misses");
      end
      va = {1'b1, 8'h03, 5'h08};
      pa_a = {24'hC0FFEE, va[11:0]};
      st_wr(1'b0, 32'h0);
      req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_IST_I, va, 0, 0, 0);
      req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_IST_I, va ^ 14'h2000, 0, 0, 0);
      nb = blocks;
      req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_FILL_I, va, pa_a, 0, 0);
      chk({blocks, mem_addr_out}, {nb + 8'h01, pa_a[35:5], 5'h0}, "fill block read");
      req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_ILT_I, va, 0, 0, 0);
      st_rd(1'b0);
      chk(d, 32'h0, "fill leaves tag");
      req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_HINV_I, va, pa_a, 0, 0);
      chk(hit, 1'b0, "invalid line no hit");
      st_wr(1'b0, {pa_a[35:12], 8'h82});
      req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_IST_I, va, 0, 0, 0);
      req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_HINV_I, va, pa_a, 0, 0);
      chk(hit, 1'b1, "valid line hit");
      req(pctag_pkg::KIND_CACHE, pctag_pkg::OP_ILT_I, va, 0, 0, 0);
      st_rd(1'b0);
      chk(d, {pa_a[35:12], 6'h0, 1'b1, ^pa_a[35:12]}, "invalidated parity");
      nb = blocks;
      @(negedge mclk_in);
      clk_en_in = 1'b0;
      req_valid_in = 1'b1;
      req_kind_in = pctag_pkg::KIND_LOAD;
      req_paddr_in = pa_c;
      repeat (3) @(negedge mclk_in);
      chk({done_out, busy_out, blocks}, {2'h0, nb}, "frozen request");
      req_valid_in = 1'b0;
      clk_en_in = 1'b1;
      end_sim;
   end
   initial
   begin
      repeat (4000) @(posedge mclk_in);
      miscompares++;
      $display("MISMATCH %0t watchdog expired", $time);
      end_sim;
   end
endmodule
